// file: src/txrx_evt_pkg.sv
// Purpose: constants for the transmit/receive event status latches
// Assumes: plain register port, 32-bit data, one clock
// Notes: offsets of both status views and the mask are local choices
package txrx_evt_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] PRIMARY_STATUS_OFS = 8'h28;
  localparam logic [7:0] AUX_STATUS_OFS = 8'h80;
  localparam logic [7:0] EVENT_MASK_OFS = 8'h90;
  localparam logic [7:0] TX_STATE_OFS = 8'h94;

  // ==========================================================
  // field positions
  localparam int RX_DONE_BIT = 6;
  localparam int TX_UNDERFLOW_BIT = 5;
  localparam int RESERVED_BIT = 4;
  localparam int JABBER_BIT = 3;
  localparam int TX_DESC_UNAVAIL_BIT = 2;
  localparam int TX_STOPPED_BIT = 1;
  localparam int TX_DONE_BIT = 0;
  localparam int FLAG_W = 7;
  localparam int DESC_UNDERFLOW_ERR_BIT = 1;
  localparam int DESC_JABBER_BIT = 14;
  localparam int DESC_INT_REQ_BIT = 31;

  // ==========================================================
  // reset values and writable masks
  localparam logic [6:0] FLAG_RESET = 7'h00;
  localparam logic [6:0] FLAG_VALID = 7'h6f;
  localparam logic [6:0] MASK_RESET = 7'h00;
  localparam logic [31:0] DESC_STATUS_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {TXEV_RUN, TXEV_SUSPEND, TXEV_STOP} txev_state_t;

endpackage

// file: src/txrx_evt_status.sv
// Purpose: sticky transmit/receive event flags with mask and interrupt
// Assumes: events are one-cycle pulses synchronous to core_clk
// Notes: the same flags answer at the primary and auxiliary offsets
//   irq is registered and trails the flags by one cycle
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module txrx_evt_status
  import txrx_evt_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic rxFrameDone,
  input wire logic txFrameDone,
  input wire logic txFirstCtrlIntReq,
  input wire logic txFifoEmpty,
  input wire logic txSending,
  input wire logic jabberExpired,
  input wire logic txDescNotOwned,
  input wire logic txStopReq,
  input wire logic txStartReq,
  input wire logic txPollDemand,
  input wire logic txAutoPoll,
  input wire logic txDescOwned,
  output logic [31:0] txDescStatus,
  output logic txDescStatusWr,
  output logic [1:0] txState,
  output logic irq
);

  // ==========================================================
  // elaboration check
  if (ADDR_W < 8)
  begin : gAddrChk
    $error("ADDR_W must hold the 8-bit offsets");
  end

  if (FLAG_W != 7)
  begin : gFlagChk
    $error("flag group must match the seven-bit flag vectors");
  end

  if ((RX_DONE_BIT >= FLAG_W) || (TX_UNDERFLOW_BIT >= FLAG_W))
  begin : gFieldChk
    $error("flag positions must lie inside the flag group");
  end

  if ((DESC_JABBER_BIT > 31) || (DESC_UNDERFLOW_ERR_BIT > 31))
  begin : gDescChk
    $error("status word bits must lie inside 32 bits");
  end

  if (FLAG_VALID[RESERVED_BIT] != 1'b0)
  begin : gRsvdChk
    $error("reserved flag bit must stay out of the writable mask");
  end

  // ==========================================================
  // event decode
  logic [6:0] evt;
  logic [6:0] clr;
  logic statusHit;
  logic underflowEvt;
  logic stopEvt;
  txev_state_t txState_r;
  txev_state_t txState_nxt;
  logic [6:0] flag_r;
  logic [6:0] mask_r;

  assign statusHit = (regAddr == ADDR_W'(PRIMARY_STATUS_OFS))
                  || (regAddr == ADDR_W'(AUX_STATUS_OFS));
  assign underflowEvt = txFifoEmpty && txSending
                     && (txState_r == TXEV_RUN);
  // each entry into stop marks the flag; reset itself does not
  assign stopEvt = (txState_nxt == TXEV_STOP)
                && (txState_r != TXEV_STOP);

  logic txStopped;
  logic rxDoneEvt;
  logic jabberEvt;
  logic descUnavailEvt;
  logic txDoneEvt;

  assign txStopped = (txState_r == TXEV_STOP);
  assign rxDoneEvt = rxFrameDone;
  assign jabberEvt = jabberExpired;
  // a missing descriptor only matters while transmit is alive
  assign descUnavailEvt = txDescNotOwned && !txStopped;
  assign txDoneEvt = txFrameDone && txFirstCtrlIntReq;

  // one vector in flag order; bit 4 has no event and stays low
  always_comb
  begin
    evt = '0;
    evt[RX_DONE_BIT] = rxDoneEvt;
    evt[TX_UNDERFLOW_BIT] = underflowEvt;
    evt[JABBER_BIT] = jabberEvt;
    evt[TX_DESC_UNAVAIL_BIT] = descUnavailEvt;
    evt[TX_STOPPED_BIT] = stopEvt;
    evt[TX_DONE_BIT] = txDoneEvt;
    evt[RESERVED_BIT] = 1'b0;
  end

  // write-one-to-clear through either view; reserved bit 4 is
  // masked so a write can never touch it
  always_comb
  begin
    clr = 7'h00;
    if (regWr && statusHit)
      clr = regWdata[6:0] & FLAG_VALID;
  end

  // ==========================================================
  // transmit process state
  logic stopCause;
  logic resumeOk;

  // jabber and software stop both force stop from any live state
  assign stopCause = jabberEvt || txStopReq;
  // without auto polling the host must also demand a poll
  assign resumeOk = txDescOwned && (txAutoPoll || txPollDemand);

  always_comb
  begin
    txState_nxt = txState_r;
    unique case (txState_r)
      TXEV_RUN:
      begin
        if (stopCause)
          txState_nxt = TXEV_STOP;
        else if (underflowEvt)
          txState_nxt = TXEV_SUSPEND;
        else if (txDescNotOwned)
          txState_nxt = TXEV_SUSPEND;
      end

      TXEV_SUSPEND:
      begin
        if (stopCause)
          txState_nxt = TXEV_STOP;
        else if (resumeOk)
          txState_nxt = TXEV_RUN;
      end

      TXEV_STOP:
      begin
        if (txStartReq)
          txState_nxt = TXEV_RUN;
      end

      default: txState_nxt = TXEV_STOP;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      txState_r <= TXEV_STOP;
    else
      txState_r <= txState_nxt;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      txState <= TXEV_STOP;
    else
      txState <= txState_nxt;
  end

  // ==========================================================
  // descriptor status write-back
  logic descWr_nxt;
  logic [31:0] descStatus_nxt;

  // the word is rebuilt from zero for every report so a stale
  // error bit of an earlier frame is never written back again
  always_comb
  begin
    descStatus_nxt = DESC_STATUS_RESET;
    descWr_nxt = 1'b0;
    if (underflowEvt)
    begin
      descStatus_nxt[DESC_UNDERFLOW_ERR_BIT] = 1'b1;
      descWr_nxt = 1'b1;
    end
    if (jabberEvt && !txStopped)
    begin
      descStatus_nxt[DESC_JABBER_BIT] = 1'b1;
      descWr_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      txDescStatusWr <= 1'b0;
    else
      txDescStatusWr <= descWr_nxt;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      txDescStatus <= DESC_STATUS_RESET;
    else
      txDescStatus <= descStatus_nxt;
  end

  // ==========================================================
  // sticky flags, one per bit; a set in the clearing cycle wins
  // so an event arriving under a clear is never lost
  logic [6:0] setVec;
  logic [6:0] clrVec;

  assign setVec = evt & FLAG_VALID;
  assign clrVec = clr & ~setVec;

  for (genvar i = 0; i < FLAG_W; i++)
  begin : gFlag
    always_ff @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
        flag_r[i] <= FLAG_RESET[i];
      else if (setVec[i])
        flag_r[i] <= 1'b1;
      else if (clrVec[i])
        flag_r[i] <= 1'b0;
    end
  end

  // ==========================================================
  // register decode; both status views share one decode
  logic hitMask;
  logic hitState;
  logic wrMask;
  logic rdStatus;
  logic rdMask;
  logic rdState;
  logic [31:0] rdData_nxt;

  assign hitMask = (regAddr == ADDR_W'(EVENT_MASK_OFS));
  assign hitState = (regAddr == ADDR_W'(TX_STATE_OFS));
  assign wrMask = regWr && hitMask;
  assign rdStatus = regRd && statusHit;
  assign rdMask = regRd && hitMask;
  assign rdState = regRd && hitState;

  // ==========================================================
  // mask; reserved bit kept at zero so it can never raise irq
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      mask_r <= MASK_RESET;
    else if (wrMask)
      mask_r <= regWdata[6:0] & FLAG_VALID;
  end

  // ==========================================================
  // interrupt; registered so irq is glitch free, one cycle behind
  logic [6:0] pend;

  assign pend = flag_r & mask_r;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq <= 1'b0;
    else
      irq <= |pend;
  end

  // ==========================================================
  // read port, data in the cycle after the strobe only
  always_comb
  begin
    rdData_nxt = 32'h0000_0000;
    if (rdStatus)
      rdData_nxt = {25'h0, flag_r & FLAG_VALID};
    else if (rdMask)
      rdData_nxt = {25'h0, mask_r};
    else if (rdState)
      rdData_nxt = {30'h0, txState_r};
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      regRdata <= 32'h0000_0000;
    else
      regRdata <= rdData_nxt;
  end

endmodule

// file: verif/testbench.sv
// Purpose: self-checking bench for the event latches
// Assumes: row = event, flags, state
// Notes: clearing through the other view checks the mirror
`timescale 1ns/1ps
module testbench
  import txrx_evt_pkg::*;
;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [11:0] ev = 12'h000;
  logic [31:0] regRdata;
  logic [1:0] txState;
  logic irq;
  int failures = 0;
  int testsRun = 0;
  logic [23:0] rows [14] = '{24'h008000, 24'h800400, 24'h400000,
    24'h600010, 24'h180201, 24'h001001, 24'h005000, 24'h020041,
    24'h003000, 24'h0400a2, 24'h008000, 24'h010022, 24'h020002,
    24'h180002};
  always #4 core_clk = ~core_clk;
  txrx_evt_status #(.ADDR_W(8)) u_dut (.core_clk(core_clk),
    .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .rxFrameDone(ev[11]), .txFrameDone(ev[10]),
    .txFirstCtrlIntReq(ev[9]), .txFifoEmpty(ev[8]), .txSending(ev[7]),
    .jabberExpired(ev[6]), .txDescNotOwned(ev[5]), .txStopReq(ev[4]),
    .txStartReq(ev[3]), .txPollDemand(ev[2]), .txAutoPoll(ev[1]),
    .txDescOwned(ev[0]), .txDescStatus(), .txDescStatusWr(),
    .txState(txState), .irq(irq));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    ev <= 12'h000;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    cmp(regRdata, e);
  endtask
  task automatic tick(input logic [11:0] v);
    ev <= v;
    @(posedge core_clk);
    ev <= 12'h000;
    #1;
  endtask
  task automatic tally_and_finish;
    $display("tests run %0d, failures %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    #1;
    cmp({30'h0, txState}, 32'h2);
    rd(AUX_STATUS_OFS, 32'h0);
    foreach (rows[i])
    begin
      tick(rows[i][23:12]);
      rd(AUX_STATUS_OFS, {25'h0, rows[i][10:4]});
      rd(PRIMARY_STATUS_OFS, {25'h0, rows[i][10:4]});
      cmp({30'h0, txState}, {30'h0, rows[i][1:0]});
      wr(PRIMARY_STATUS_OFS, 32'hffff_ffff);
    end
    // event wins over a clear landing on the same edge
    ev <= 12'h800;
    wr(PRIMARY_STATUS_OFS, 32'h40);
    rd(AUX_STATUS_OFS, 32'h40);
    cmp({31'h0, irq}, 32'h0);
    wr(EVENT_MASK_OFS, 32'h40);
    rd(EVENT_MASK_OFS, 32'h40);
    cmp({31'h0, irq}, 32'h1);
    wr(AUX_STATUS_OFS, 32'h40);
    @(posedge core_clk);
    #1;
    cmp({31'h0, irq}, 32'h0);
    wr(8'h44, 32'hffff_ffff);
    rd(8'h44, 32'h0);
    rd(TX_STATE_OFS, 32'h2);
    tick(12'h800);
    arst_n <= 1'b0;
    @(posedge core_clk);
    arst_n <= 1'b1;
    #1;
    rd(AUX_STATUS_OFS, 32'h0);
    rd(EVENT_MASK_OFS, 32'h0);
    tally_and_finish;
  end
  initial
  begin
    #5000;
    failures++;
    tally_and_finish;
  end
endmodule

// file: verif/txrx_evt_chk.sv
// Purpose: port checker for the event latches
// Assumes: flags are seen only through reads
// Notes: bound to the top module by name
`timescale 1ns/1ps
module txrx_evt_chk
  import txrx_evt_pkg::*;
#(parameter int ADDR_W = 8)
(
  input logic core_clk,
  input logic arst_n,
  input logic [ADDR_W-1:0] regAddr,
  input logic regWr,
  input logic regRd,
  input logic [31:0] regRdata,
  input logic rxFrameDone,
  input logic txFrameDone,
  input logic txFirstCtrlIntReq,
  input logic txFifoEmpty,
  input logic txSending,
  input logic jabberExpired,
  input logic txStopReq,
  input logic txDescOwned,
  input logic [31:0] txDescStatus,
  input logic txDescStatusWr,
  input logic [1:0] txState,
  input logic irq
);
  // ============
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  wire rdAux = regRd && regAddr == AUX_STATUS_OFS;
  wire uflow = txFifoEmpty && txSending && txState == 2'h0;
  chk_jabber_stop: assert property (jabberExpired && txState == 2'h0
    |=> txState == 2'h2 && txDescStatusWr && txDescStatus[14])
    else $error("jabber did not stop transmit");
  chk_uflow_suspend: assert property (uflow && !jabberExpired
    && !txStopReq |=> txState == 2'h1 && txDescStatusWr && txDescStatus[1])
    else $error("underflow did not suspend");
  chk_rdata_idle: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data outside read cycle");
  chk_rsvd_zero: assert property (rdAux |=> regRdata[31:7] == 25'h0
    && !regRdata[4]) else $error("reserved bits not zero");
  chk_irq_clear: assert property ($fell(irq) |-> $past(regWr, 2))
    else $error("irq fell without a write");
  chk_rx_flag: assert property (rxFrameDone ##1 rdAux
    |=> regRdata[6]) else $error("rx done flag missing");
  chk_txdone_flag: assert property (txFrameDone && txFirstCtrlIntReq
    ##1 rdAux |=> regRdata[0]) else $error("tx done flag missing");
  chk_suspend_hold: assert property (txState == 2'h1 && !txDescOwned
    && !txStopReq |=> txState != 2'h0) else $error("left suspend early");
  cover property (txState == 2'h1);
  cover property ($rose(irq));
  cover property (txDescStatusWr && txDescStatus[14]);
endmodule

bind txrx_evt_status txrx_evt_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
